// ### pkg/gpt_consts.svh
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH
// What this block does
// RULE1 - 16-bit auto-reload counter: up, down, centre
// RULE2 - prescaler divides by any integer 1..65536
// RULE3 - four-channel variant: four capture/compare/PWM/one-pulse channels
// RULE4 - two-channel variant: two channels, same functions
// RULE5 - DMA requests only on four-channel variant
// RULE6 - sibling trigger can synchronize, start, clock
// RULE7 - debug freeze stops counter while halted; link and hall restarts still zero it while frozen
// RULE8 - four-channel variant decodes encoder and hall
// RULE9 - two-channel variant clocked from low-speed oscillator
// RULE10 - selectable timer events trigger converter start
// RULE11 - capture inputs routed through firmware multiplexer
// RULE12 - overflow/underflow raises update, reloads buffered settings
`define GPT_CNT_W       16
`define GPT_CNT_RESET   16'h0000
`define GPT_ARR_RESET   16'hffff
`define GPT_PSC_RESET   16'h0000
`define GPT_CMP_RESET   16'h0000
`define GPT_SRC_PER_CH  4
`define GPT_SEL_W       2
`define GPT_EVT_SEL_W   3
`define GPT_HALL_W      3
`define GPT_FULL_CH     4
`endif

// ### pkg/gpt_pkg.sv
package gpt_pkg;
    // counting direction scheme
    typedef enum logic [1:0] {
        gpt_cnt_up     = 2'b00,
        gpt_cnt_down   = 2'b01,
        gpt_cnt_center = 2'b10
    } gpt_cnt_mode_t;

    // where the prescaler input ticks come from
    typedef enum logic [1:0] {
        gpt_clk_internal = 2'b00,
        gpt_clk_lse      = 2'b01,
        gpt_clk_link     = 2'b10,
        gpt_clk_encoder  = 2'b11
    } gpt_clk_src_t;

    // what the sibling timer's trigger does to this one
    typedef enum logic [1:0] {
        gpt_link_none  = 2'b00,
        gpt_link_reset = 2'b01,
        gpt_link_gate  = 2'b10,
        gpt_link_start = 2'b11
    } gpt_link_mode_t;

    // per-channel function
    typedef enum logic [1:0] {
        gpt_ch_capture = 2'b00,
        gpt_ch_toggle  = 2'b01,
        gpt_ch_pwm     = 2'b10,
        gpt_ch_pwm_inv = 2'b11
    } gpt_ch_mode_t;
endpackage

// ### logic/gpt_channel.sv
`include "gpt_consts.svh"
module gpt_channel (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // configuration
    input  wire gpt_pkg::gpt_ch_mode_t mode,
    input  wire logic [15:0]          compare,
    input  wire logic                 cap_falling,
    // timebase
    input  wire logic                 load,
    input  wire logic [15:0]          count,
    input  wire logic                 cnt_tick,
    // filtered capture input
    input  wire logic                 cap_lvl,
    // results
    output logic                      ch_out,
    output logic [15:0]               capture,
    output logic                      evt
);
    logic [15:0] cmp_sh;
    logic        cap_d;

    // edge and match decode
    wire is_cap   = (mode == gpt_pkg::gpt_ch_capture);
    wire cap_edge = cap_falling ? (cap_d & ~cap_lvl) : (~cap_d & cap_lvl);
    wire match    = cnt_tick & (count == cmp_sh);
    wire pwm_lvl  = (count < cmp_sh);

    // compare value is buffered so a mid-period write cannot glitch pwm
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmp_sh <= `GPT_CMP_RESET;
            cap_d  <= 1'b0;
        end else begin
            cap_d <= cap_lvl;
            if (load)
                cmp_sh <= compare; // [RULE12]
        end
    end

    // capture, compare and pwm outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch_out  <= 1'b0;
            capture <= `GPT_CNT_RESET;
            evt     <= 1'b0;
        end else begin
            evt <= is_cap ? cap_edge : match; // [RULE3] [RULE4]
            if (is_cap && cap_edge)
                capture <= count;
            unique case (mode)
                gpt_pkg::gpt_ch_capture: ch_out <= 1'b0;
                gpt_pkg::gpt_ch_toggle:  ch_out <= ch_out ^ match;
                gpt_pkg::gpt_ch_pwm:     ch_out <= pwm_lvl;
                gpt_pkg::gpt_ch_pwm_inv: ch_out <= ~pwm_lvl;
            endcase
        end
    end
endmodule

// ### logic/gpt_timer.sv
`include "gpt_consts.svh"
module gpt_timer #(
    parameter int NUM_CH = `GPT_FULL_CH
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // timebase configuration
    input  wire logic                    enable,
    input  wire gpt_pkg::gpt_cnt_mode_t  cnt_mode,
    input  wire gpt_pkg::gpt_clk_src_t   clk_src,
    input  wire logic [15:0]             prescale,
    input  wire logic [15:0]             auto_reload,
    input  wire logic                    one_pulse,
    input  wire gpt_pkg::gpt_link_mode_t link_mode,
    input  wire logic                    hall_en,
    // debug
    input  wire logic                    debug_freeze,
    input  wire logic                    cpu_halted,
    // channel configuration
    input  wire gpt_pkg::gpt_ch_mode_t   ch_mode     [NUM_CH],
    input  wire logic [15:0]             compare     [NUM_CH],
    input  wire logic [1:0]              ch_in_sel   [NUM_CH],
    input  wire logic [NUM_CH-1:0]       cap_falling,
    // event routing
    input  wire logic [2:0]              trig_sel,
    input  wire logic [2:0]              adc_sel,
    // pins and sibling timer
    input  wire logic [NUM_CH*4-1:0]     ch_src,
    input  wire logic [2:0]              hall_in,
    input  wire logic                    lse_clk_in,
    input  wire logic                    link_in,
    // counter state
    output logic [15:0]                  count,
    output logic                         count_down,
    // channel results
    output logic [NUM_CH-1:0]            ch_out,
    output logic [15:0]                  capture     [NUM_CH],
    output logic [NUM_CH-1:0]            ch_evt,
    // events
    output logic                         update_evt,
    output logic                         trig_out,
    output logic                         adc_trig,
    output logic [NUM_CH:0]              dma_req
);
    // the variant follows from the channel count
    localparam bit FULL = (NUM_CH == `GPT_FULL_CH);
    localparam int SRC_W = NUM_CH * `GPT_SRC_PER_CH;
    localparam int AW = SRC_W + `GPT_HALL_W + 2;

    // three-stage synchroniser for every pin; s1 feeds s2 only
    logic [AW-1:0] s1, s2, s3, filt, filt_d;
    wire  [AW-1:0] pins  = {link_in, lse_clk_in, hall_in, ch_src};
    wire  [AW-1:0] agree = ~(s2 ^ s3);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1     <= '0;
            s2     <= '0;
            s3     <= '0;
            filt   <= '0;
            filt_d <= '0;
        end else begin
            s1     <= pins;
            s2     <= s1;
            s3     <= s2;
            filt   <= (s3 & agree) | (filt & ~agree);
            filt_d <= filt;
        end
    end

    // pin field decode after filtering
    wire [SRC_W-1:0] src_f  = filt[SRC_W-1:0];
    wire [2:0]       hall_f = filt[SRC_W +: 3];
    wire [2:0]       hall_p = filt_d[SRC_W +: 3];
    wire             lse_r  = filt[AW-2] & ~filt_d[AW-2];
    wire             link_l = filt[AW-1];
    wire             link_r = link_l & ~filt_d[AW-1];

    // capture input routing per channel
    logic [NUM_CH-1:0] chan_in;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_route
            wire [1:0] sel = ch_in_sel[g];
            assign chan_in[g] = src_f[g*4 + sel]; // [RULE11]
        end
    endgenerate

    // hall sensors replace channel 0 input with their xor
    wire hall_on  = FULL & hall_en;
    wire hall_x   = ^hall_f; // [RULE8]
    wire hall_chg = hall_on & (hall_f != hall_p);
    logic [NUM_CH-1:0] cap_lvl;
    assign cap_lvl = {chan_in[NUM_CH-1:1], hall_on ? hall_x : chan_in[0]};

    // quadrature decode on channels 0 and 1, four counts per cycle
    logic enc_a_d;
    logic enc_b_d;
    wire enc_a    = chan_in[0];
    wire enc_b    = chan_in[1];
    wire enc_step = (enc_a ^ enc_a_d) | (enc_b ^ enc_b_d);
    wire enc_up   = enc_a ^ enc_b_d; // [RULE8]
    wire enc_mode = FULL & (clk_src == gpt_pkg::gpt_clk_encoder);

    // tick source selection; lse only exists on the small variant
    wire lse_tick = !FULL & lse_r; // [RULE9]
    wire enc_tick = FULL & enc_step;
    wire src_tick =
        (clk_src == gpt_pkg::gpt_clk_internal) ? 1'b1     :
        (clk_src == gpt_pkg::gpt_clk_lse)      ? lse_tick :
        (clk_src == gpt_pkg::gpt_clk_link)     ? link_r   : // [RULE6]
                                                 enc_tick;

    // run control: start, gate, freeze and one-pulse stop
    logic run;
    logic op_done;
    wire frozen   = debug_freeze & cpu_halted; // [RULE7]
    wire gated    = (link_mode == gpt_pkg::gpt_link_gate) & ~link_l;
    wire start_ok = (link_mode != gpt_pkg::gpt_link_start) | link_r;
    wire link_rst = (link_mode == gpt_pkg::gpt_link_reset) & link_r;
    wire active   = enable & run & ~frozen & ~gated;

    // prescaler: divide by prescale + 1
    logic [15:0] psc_cnt;
    logic [15:0] psc_sh;
    logic [15:0] arr_sh;
    wire psc_in   = active & src_tick;
    wire psc_wrap = (psc_cnt == psc_sh);
    wire cnt_tick = psc_in & psc_wrap; // [RULE2]

    // counter stepping and wrap decode
    logic center_dn;
    wire is_center = (cnt_mode == gpt_pkg::gpt_cnt_center);
    wire dn = enc_mode ? ~enc_up :
              (cnt_mode == gpt_pkg::gpt_cnt_down) | (is_center & center_dn);
    wire at_top  = (count == arr_sh);
    wire at_bot  = (count == `GPT_CNT_RESET);
    wire wrap_hi = ~dn & at_top;
    wire wrap_lo = dn & at_bot;
    wire wrapped = cnt_tick & (wrap_hi | wrap_lo);
    wire [15:0] cnt_inc = count + 16'h0001;
    wire [15:0] cnt_dec = count - 16'h0001;
    wire [15:0] next_count =
        (wrap_hi & is_center & ~at_bot) ? cnt_dec :
        wrap_hi                         ? `GPT_CNT_RESET :
        (wrap_lo & is_center & ~at_top) ? cnt_inc :
        wrap_lo                         ? arr_sh : // [RULE1]
        dn                              ? cnt_dec : cnt_inc;
    wire restart = link_rst | hall_chg; // [RULE6]
    wire update  = wrapped | restart;   // [RULE12]
    // settings also load while idle so a fresh start sees them at once
    wire load    = update | ~run;

    // run and one-pulse state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run     <= 1'b0;
            op_done <= 1'b0;
        end else if (!enable) begin
            run     <= 1'b0;
            op_done <= 1'b0;
        end else if (run && one_pulse && wrapped) begin
            run     <= 1'b0; // [RULE3]
            op_done <= 1'b1;
        end else if (!run && !op_done && start_ok) begin
            run <= 1'b1; // [RULE6]
        end
    end

    // prescaler and buffered settings
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            psc_cnt <= `GPT_PSC_RESET;
            psc_sh  <= `GPT_PSC_RESET;
            arr_sh  <= `GPT_ARR_RESET;
        end else begin
            if (restart || (psc_in && psc_wrap) || !run)
                psc_cnt <= `GPT_PSC_RESET;
            else if (psc_in)
                psc_cnt <= psc_cnt + 16'h0001;
            if (load) begin
                psc_sh <= prescale; // [RULE12]
                arr_sh <= auto_reload;
            end
        end
    end

    // main counter and direction
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count     <= `GPT_CNT_RESET;
            center_dn <= 1'b0;
            enc_a_d   <= 1'b0;
            enc_b_d   <= 1'b0;
        end else begin
            enc_a_d <= enc_a;
            enc_b_d <= enc_b;
            if (restart) begin
                count     <= `GPT_CNT_RESET;
                center_dn <= 1'b0;
            end else if (cnt_tick) begin
                count <= next_count; // [RULE1]
                if (is_center && (wrap_hi || wrap_lo))
                    center_dn <= ~center_dn;
            end
        end
    end

    assign count_down = dn;

    // capture/compare channels
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            gpt_channel u_ch (
                .clock       (clock),
                .rst_b       (rst_b),
                .mode        (ch_mode[g]),
                .compare     (compare[g]),
                .cap_falling (cap_falling[g]),
                .load        (load),
                .count       (count),
                .cnt_tick    (cnt_tick),
                .cap_lvl     (cap_lvl[g]),
                .ch_out      (ch_out[g]),
                .capture     (capture[g]),
                .evt         (ch_evt[g])
            );
        end
    endgenerate

    // event routing: index 0 is update, index n is channel n-1
    logic upd_q;
    wire [NUM_CH:0] evts    = {ch_evt, upd_q};
    wire            trig_ok = (trig_sel <= 3'(NUM_CH));
    wire            adc_ok  = (adc_sel <= 3'(NUM_CH));

    // routed events are registered pulses, two cycles after the cause
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            upd_q      <= 1'b0;
            update_evt <= 1'b0;
            trig_out   <= 1'b0;
            adc_trig   <= 1'b0;
            dma_req    <= '0;
        end else begin
            upd_q      <= update;
            update_evt <= upd_q;
            trig_out   <= trig_ok & evts[trig_sel]; // [RULE6]
            adc_trig   <= adc_ok & evts[adc_sel];   // [RULE10]
            dma_req    <= FULL ? evts : '0;         // [RULE5]
        end
    end
endmodule

// ### verification/gpt_timer_asserts.sv
module gpt_timer_asserts #(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rst_b,
    // configuration
    input wire logic                   enable,
    input wire gpt_pkg::gpt_cnt_mode_t cnt_mode,
    input wire gpt_pkg::gpt_clk_src_t  clk_src,
    input wire gpt_pkg::gpt_link_mode_t link_mode,
    input wire logic                   hall_en,
    input wire logic                   debug_freeze,
    input wire logic                   cpu_halted,
    input wire logic [2:0]             trig_sel,
    input wire logic [2:0]             adc_sel,
    // results
    input wire logic [15:0]            count,
    input wire logic                   count_down,
    input wire logic [15:0]            capture [NUM_CH],
    input wire logic [NUM_CH-1:0]      ch_evt,
    input wire logic                   update_evt,
    input wire logic                   trig_out,
    input wire logic                   adc_trig,
    input wire logic [NUM_CH:0]        dma_req
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // link and hall resets zero the count, so steps are only fixed without them
    wire plain = link_mode == gpt_pkg::gpt_link_none && !hall_en
                 && clk_src == gpt_pkg::gpt_clk_internal;
    wire up_pl = plain && cnt_mode == gpt_pkg::gpt_cnt_up;
    wire dn_pl = plain && cnt_mode == gpt_pkg::gpt_cnt_down;
    wire ct_pl = plain && cnt_mode == gpt_pkg::gpt_cnt_center;
    wire frozen = plain && debug_freeze && cpu_halted;

    hold_frozen_a: assert property ($past(frozen)
        |-> count == $past(count)) else $error("count moved while frozen");
    up_step_a: assert property ($past(up_pl) && count != 16'h0
        && count != $past(count) |-> count == $past(count) + 16'h1)
        else $error("up count skipped");
    down_step_a: assert property ($past(dn_pl) && $past(count) != 16'h0
        && count != $past(count) |-> count == $past(count) - 16'h1)
        else $error("down count skipped");
    center_step_a: assert property ($past(ct_pl) && count != $past(count)
        |-> count == $past(count) + 16'h1 || count == $past(count) - 16'h1)
        else $error("centre count jumped");
    // update shows two edges after the wrap, when count has read zero a cycle
    wrap_update_a: assert property (update_evt && $past(up_pl, 2)
        |-> $past(count) == 16'h0) else $error("update without wrap");
    dma_upd_a: assert property (dma_req[0] == update_evt)
        else $error("update request differs from update");
    dma_chan_a: assert property (dma_req[NUM_CH:1] == $past(ch_evt))
        else $error("channel request differs from event");
    trig_upd_a: assert property (trig_sel == 3'h0 && $past(trig_sel) == 3'h0
        |-> trig_out == update_evt) else $error("trigger not update");
    adc_upd_a: assert property (adc_sel == 3'h0 && $past(adc_sel) == 3'h0
        |-> adc_trig == update_evt) else $error("converter start not update");
    cap_evt_a: assert property (capture[1] != $past(capture[1])
        |-> ch_evt[1]) else $error("capture changed without event");
    dir_down_a: assert property (cnt_mode == gpt_pkg::gpt_cnt_down
        && $past(cnt_mode) == gpt_pkg::gpt_cnt_down |-> count_down)
        else $error("down mode counting up");

    // main scenarios
    cov_upd: cover property (update_evt);
    cov_cap: cover property (ch_evt[1]);
    cov_frz: cover property (frozen ##1 frozen);
endmodule

bind gpt_timer gpt_timer_asserts #(.NUM_CH(NUM_CH)) chk (
    .clock, .rst_b, .enable, .cnt_mode, .clk_src, .link_mode, .hall_en,
    .debug_freeze, .cpu_halted, .trig_sel, .adc_sel, .count, .count_down,
    .capture, .ch_evt, .update_evt, .trig_out, .adc_trig, .dma_req
);

// ### verification/gpt_pins_model.sv
module gpt_pins_model (
    // clock
    input  wire logic        clock,
    // level and source for channel one
    input  wire logic        lvl,
    input  wire logic [1:0]  sel,
    // pins toward the timer
    output logic [15:0]      ch_src,
    output logic [2:0]       hall_in,
    output logic             lse_clk_in,
    output logic             link_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] noise = 16'h0;

    // unused sources toggle every cycle, which the filter rejects, so a
    // wrong mux pick never captures
    always @(negedge clock) noise <= ~noise;
    assign ch_src = (noise & ~(16'h0010 << sel))
                    | ({15'h0, lvl} << (5'h4 + 5'(sel)));
    // hall, oscillator and sibling idle: those modes stay off here
    assign hall_in = 3'h0;
    assign lse_clk_in = 1'b0;
    assign link_in = 1'b0;
endmodule

// ### verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clock, rst_b, enable, debug_freeze, cpu_halted;
    gpt_pkg::gpt_cnt_mode_t cnt_mode;
    logic [15:0]            prescale, auto_reload, count, ch_src;
    gpt_pkg::gpt_ch_mode_t  ch_mode [4];
    logic [15:0]            compare [4];
    logic [15:0]            capture [4];
    logic [1:0]             ch_in_sel [4];
    logic [3:0]             cap_falling, ch_out, ch_evt;
    logic [2:0]             trig_sel, adc_sel, hall_in;
    logic                   lvl, lse_clk_in, link_in, count_down, one_pulse;
    logic                   update_evt, trig_out, adc_trig;
    logic [4:0]             dma_req;
    int                     err_total = 0;
    int                     checks = 0;

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    gpt_pins_model pins (.clock, .lvl, .sel(ch_in_sel[1]), .ch_src,
        .hall_in, .lse_clk_in, .link_in);
    gpt_timer #(.NUM_CH(4)) dut (.clock, .rst_b, .enable, .cnt_mode,
        .clk_src(gpt_pkg::gpt_clk_internal), .prescale, .auto_reload,
        .one_pulse, .link_mode(gpt_pkg::gpt_link_none),
        .hall_en(1'b0), .debug_freeze, .cpu_halted, .ch_mode, .compare,
        .ch_in_sel, .cap_falling, .trig_sel, .adc_sel, .ch_src, .hall_in,
        .lse_clk_in, .link_in, .count, .count_down, .ch_out, .capture,
        .ch_evt, .update_evt, .trig_out, .adc_trig, .dma_req);

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ten cycles of reset, released off the rising edge
    task automatic reset_dut();
        @(negedge clock);
        rst_b = 1'b0;
        enable = 1'b0;
        cpu_halted = 1'b0;
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
    endtask

    // counter state is not cleared by enable, so each test resets
    task automatic run(input gpt_pkg::gpt_cnt_mode_t md);
        int p, top, m, d, dir, n, w, ups, wr;
        logic hold, tgl;
        logic [15:0] prev;
        p = $urandom % 3;
        top = 3 + $urandom % 6;
        reset_dut();
        cnt_mode = md;
        prescale = 16'(p);
        auto_reload = 16'(top);
        compare[0] = 16'(1 + $urandom % top);
        ch_in_sel[1] = 2'($urandom % 4);
        enable = 1'b1;
        m = (md == gpt_pkg::gpt_cnt_down) ? top : 1;
        for (w = 0; w < 100 && count !== 16'(m); w++) @(negedge clock);
        chk16(count, 16'(m));
        {d, dir, ups, wr} = {32'd0, 32'd1, 32'd0, 32'd0};
        // dir 0 means counting down; down mode never changes it
        if (md == gpt_pkg::gpt_cnt_down) dir = 0;
        // the one tick so far started from zero
        tgl = (compare[3] == 16'h0000);
        prev = count;
        for (n = 0; n < 60; n++) begin
            hold = ($urandom % 4) == 0;
            cpu_halted = hold;
            @(negedge clock);
            if (update_evt === 1'b1) ups++;
            if (!hold) d++;
            if (d > p) begin
                d = 0;
                tgl ^= (16'(m) == compare[3]);
                if (md == gpt_pkg::gpt_cnt_up) begin
                    wr += int'(m == top);
                    m = (m == top) ? 0 : m + 1;
                end else if (md == gpt_pkg::gpt_cnt_down) begin
                    m = (m == 0) ? top : m - 1;
                end else begin
                    dir = (m == top) ? 0 : (m == 0) ? 1 : dir;
                    m = (dir == 1) ? m + 1 : m - 1;
                end
            end
            chk16(count, 16'(m));
            chk1(ch_out[0], prev < compare[0]);
            chk1(ch_out[2], !(prev < compare[2]));
            chk1(ch_out[3], tgl);
            chk1(count_down, dir == 0);
            prev = count;
        end
        // frozen tail lets late updates land and keeps capture steady
        cpu_halted = 1'b1;
        repeat (3) begin
            @(negedge clock);
            if (update_evt === 1'b1) ups++;
        end
        if (md == gpt_pkg::gpt_cnt_up) chk16(16'(ups), 16'(wr));
        cap_falling[1] = lvl;
        trig_sel = 3'h2;
        adc_sel = 3'h2;
        lvl = ~lvl;
        for (w = 0; w < 20 && ch_evt[1] !== 1'b1; w++) @(negedge clock);
        chk1(ch_evt[1], 1'b1);
        chk16(capture[1], count);
        @(negedge clock);
        chk1(trig_out, 1'b1);
        chk1(adc_trig, 1'b1);
        trig_sel = 3'h0;
        adc_sel = 3'h0;
        $display("test mode %0d done", md);
    endtask

    // one-pulse stops at zero after the first wrap; a halt without the
    // freeze option must not stop the counter
    task automatic one_shot();
        int w;
        reset_dut();
        debug_freeze = 1'b0;
        cpu_halted = 1'b1;
        cnt_mode = gpt_pkg::gpt_cnt_up;
        prescale = 16'h0000;
        auto_reload = 16'h0004;
        one_pulse = 1'b1;
        enable = 1'b1;
        for (w = 0; w < 100 && count !== 16'h0004; w++) @(negedge clock);
        chk16(count, 16'h0004);
        repeat (8) @(negedge clock);
        chk16(count, 16'h0000);
        $display("test one-pulse done");
    endtask

    initial begin
        {rst_b, enable, cpu_halted, lvl, one_pulse} = 5'h00;
        debug_freeze = 1'b1;
        cnt_mode = gpt_pkg::gpt_cnt_up;
        {prescale, auto_reload} = 32'h0;
        {cap_falling, trig_sel, adc_sel} = 10'h0;
        void'($urandom(41488));
        for (int i = 0; i < 4; i++) begin
            ch_mode[i] = gpt_pkg::gpt_ch_mode_t'($urandom % 4);
            compare[i] = 16'($urandom % 8);
            ch_in_sel[i] = 2'($urandom % 4);
        end
        ch_mode[0] = gpt_pkg::gpt_ch_pwm;
        ch_mode[1] = gpt_pkg::gpt_ch_capture;
        ch_mode[2] = gpt_pkg::gpt_ch_pwm_inv;
        ch_mode[3] = gpt_pkg::gpt_ch_toggle;
        for (int k = 0; k < 3; k++) run(gpt_pkg::gpt_cnt_mode_t'(k));
        one_shot();
        results();
    end

    // four tests of about 280 cycles in all; 7500 cycles, some 27 times that, is a hang
    initial begin
        #750000;
        err_total++;
        results();
    end
endmodule
